// [hw/drof_file.sv]
// Data, address and stack register file with sized, bit-field, quad and BCD access
`timescale 1ns/1ps
module drof_file import drof_pkg::*; (
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              rst_b,
    // Sized write port
    input  wire logic              wr_en,
    input  wire logic [SEL_W-1:0]  wr_sel,
    input  wire logic [1:0]        wr_size,
    input  wire logic [DATA_W-1:0] wr_data,
    // Sized read port
    input  wire logic              rd_en,
    input  wire logic [SEL_W-1:0]  rd_sel,
    input  wire logic [1:0]        rd_size,
    input  wire logic [1:0]        rd_bcd,
    output logic      [DATA_W-1:0] rd_data,
    // Bit-field port
    input  wire logic [1:0]        bf_op,
    input  wire logic [2:0]        bf_reg,
    input  wire logic [4:0]        bf_offset,
    input  wire logic [4:0]        bf_width,
    input  wire logic              bf_signed,
    input  wire logic [DATA_W-1:0] bf_ins_data,
    output logic      [DATA_W-1:0] bf_data,
    // Quad-word write
    input  wire logic              q_en,
    input  wire logic [2:0]        q_hi_sel,
    input  wire logic [2:0]        q_lo_sel,
    input  wire logic [63:0]       q_data
);
    logic [DATA_W-1:0] reg_q [NUM_REGS];
    logic [LANES-1:0]  be_w  [NUM_REGS];
    logic [DATA_W-1:0] wd_w  [NUM_REGS];
    logic [DATA_W-1:0] rd_q, rd_d, bf_q, bf_d;
    logic [DATA_W-1:0] rd_cur, bf_cur, bf_rot, bf_mask, bf_put, bf_new;
    logic [63:0]       rot_t, back_t;
    logic [5:0]        bf_w6, bf_sh;
    logic [DATA_W-1:0] rd_sz;

    for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
        drof_reg u_reg (
            .mclk  (mclk),
            .rst_b (rst_b),
            .be    (be_w[i]),
            .wd    (wd_w[i]),
            .q     (reg_q[i])
        );
    end

    function automatic logic [LANES-1:0] size_lanes(input logic [1:0] sz);
        size_lanes = (sz == SZ_BYTE) ? BE_BYTE : (sz == SZ_WORD) ? BE_WORD : BE_LONG;
    endfunction

    // Bit-field datapath: rotate so field bit zero sits at bit 31
    always_comb begin
        bf_cur  = reg_q[{2'b00, bf_reg}];
        bf_w6   = (bf_width == 5'h00) ? 6'h20 : {1'b0, bf_width};
        bf_sh   = 6'h20 - bf_w6;
        rot_t   = {bf_cur, bf_cur} << bf_offset;
        bf_rot  = rot_t[63:32];
        bf_mask = 32'hFFFF_FFFF << bf_sh;
        bf_put  = (bf_rot & ~bf_mask) | ((bf_ins_data << bf_sh) & bf_mask);
        back_t  = {bf_put, bf_put} >> bf_offset;
        bf_new  = back_t[31:0];
        if (bf_signed) begin
            bf_d = DATA_W'($signed(bf_rot) >>> bf_sh);
        end else begin
            bf_d = bf_rot >> bf_sh;
        end
        // Last field stands until the next field request
        if (bf_op == BF_NONE) begin
            bf_d = bf_q;
        end
    end

    // Write arbitration; on the same register quad beats insert beats plain write
    always_comb begin
        for (int i = 0; i < NUM_REGS; i++) begin
            be_w[i] = 4'h0;
            wd_w[i] = wr_data;
            if (wr_en && wr_sel == SEL_W'(i)) begin
                if (i < NUM_DATA) begin
                    be_w[i] = size_lanes(wr_size);
                end else begin
                    // Address destinations always take the whole register
                    be_w[i] = BE_LONG;
                    if (wr_size != SZ_LONG) begin
                        wd_w[i] = {{16{wr_data[15]}}, wr_data[15:0]};
                    end
                end
            end
            if (bf_op == BF_INS && bf_reg == 3'(i) && i < NUM_DATA) begin
                be_w[i] = BE_LONG;
                wd_w[i] = bf_new;
            end
            if (q_en && q_lo_sel == 3'(i) && i < NUM_DATA) begin
                be_w[i] = BE_LONG;
                wd_w[i] = q_data[31:0];
            end
            if (q_en && q_hi_sel == 3'(i) && i < NUM_DATA) begin
                be_w[i] = BE_LONG;
                wd_w[i] = q_data[63:32];
            end
        end
    end

    // Read path; unmapped selects read zero
    always_comb begin
        rd_cur = (rd_sel < SEL_W'(NUM_REGS)) ? reg_q[rd_sel] : REG_RESET;
        unique case (rd_size)
            SZ_BYTE: begin
                // Address registers have no byte form, give the word
                rd_sz = (rd_sel < SEL_W'(NUM_DATA)) ? {24'h0, rd_cur[7:0]}
                                                    : {16'h0, rd_cur[15:0]};
            end
            SZ_WORD: rd_sz = {16'h0, rd_cur[15:0]};
            default: rd_sz = rd_cur;
        endcase
        unique case (rd_bcd)
            BCD_PACK: rd_d = {24'h0, rd_sz[11:8], rd_sz[3:0]};
            BCD_UNPK: rd_d = {16'h0, 4'h0, rd_sz[7:4], 4'h0, rd_sz[3:0]};
            default:  rd_d = rd_sz;
        endcase
        if (!rd_en) begin
            rd_d = rd_q;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            rd_q <= REG_RESET;
            bf_q <= REG_RESET;
        end else begin
            rd_q <= rd_d;
            bf_q <= bf_d;
        end
    end

    assign rd_data = rd_q;
    assign bf_data = bf_q;

    // Helpers for checks
    logic [DATA_W-1:0] wr_cur;
    logic              wr_only;
    assign wr_cur  = (wr_sel < SEL_W'(NUM_REGS)) ? reg_q[wr_sel] : REG_RESET;
    assign wr_only = wr_en && wr_sel < SEL_W'(NUM_DATA) && !q_en && bf_op != BF_INS;

    property p_long_write;
        @(posedge mclk) disable iff (!rst_b)
        wr_only && wr_size == SZ_LONG |=> reg_q[$past(wr_sel)] == $past(wr_data);
    endproperty
    a_long_write: assert property (p_long_write) else $error("long write lost");

    property p_byte_keep;
        @(posedge mclk) disable iff (!rst_b)
        wr_only && wr_size == SZ_BYTE |=>
            reg_q[$past(wr_sel)] == {$past(wr_cur[31:8]), $past(wr_data[7:0])};
    endproperty
    a_byte_keep: assert property (p_byte_keep) else $error("byte write bad");

    property p_word_keep;
        @(posedge mclk) disable iff (!rst_b)
        wr_only && wr_size == SZ_WORD |=>
            reg_q[$past(wr_sel)][31:16] == $past(wr_cur[31:16]);
    endproperty
    a_word_keep: assert property (p_word_keep) else $error("word write touched high");

    property p_rd_byte;
        @(posedge mclk) disable iff (!rst_b)
        rd_en && rd_sel < SEL_W'(NUM_DATA) && rd_size == SZ_BYTE && rd_bcd == BCD_NONE
        |=> rd_data == {24'h0, $past(rd_cur[7:0])};
    endproperty
    a_rd_byte: assert property (p_rd_byte) else $error("byte read bad");

    property p_rd_long;
        @(posedge mclk) disable iff (!rst_b)
        rd_en && rd_size == SZ_LONG && rd_bcd == BCD_NONE |=> rd_data[31] == $past(rd_cur[31]);
    endproperty
    a_rd_long: assert property (p_rd_long) else $error("msb misplaced");

    property p_bf_msb;
        @(posedge mclk) disable iff (!rst_b)
        bf_op == BF_EXT && bf_offset == 5'h00 && bf_width == 5'h01 && !bf_signed
        |=> bf_data == {31'h0, $past(bf_cur[31])};
    endproperty
    a_bf_msb: assert property (p_bf_msb) else $error("field bit zero not msb");

    property p_bf_wrap;
        @(posedge mclk) disable iff (!rst_b)
        bf_op == BF_EXT && bf_offset == 5'h1F && bf_width == 5'h02 && !bf_signed
        |=> bf_data == {30'h0, $past(bf_cur[0]), $past(bf_cur[31])};
    endproperty
    a_bf_wrap: assert property (p_bf_wrap) else $error("field did not wrap");

    property p_bf_full;
        @(posedge mclk) disable iff (!rst_b)
        bf_op == BF_EXT && bf_width == 5'h00 && bf_offset == 5'h00 |=> bf_data == $past(bf_cur);
    endproperty
    a_bf_full: assert property (p_bf_full) else $error("32-bit field bad");

    property p_quad;
        @(posedge mclk) disable iff (!rst_b)
        q_en |=> reg_q[{2'b00, $past(q_hi_sel)}] == $past(q_data[63:32]);
    endproperty
    a_quad: assert property (p_quad) else $error("quad high half lost");

    property p_pack;
        @(posedge mclk) disable iff (!rst_b)
        rd_en && rd_size == SZ_WORD && rd_bcd == BCD_PACK
        |=> rd_data[7:0] == {$past(rd_cur[11:8]), $past(rd_cur[3:0])};
    endproperty
    a_pack: assert property (p_pack) else $error("pack bad");

    property p_unpack;
        @(posedge mclk) disable iff (!rst_b)
        rd_en && rd_bcd == BCD_UNPK |=> rd_data[15:12] == 4'h0 && rd_data[11:8] == $past(rd_cur[7:4]);
    endproperty
    a_unpack: assert property (p_unpack) else $error("unpack bad");

    property p_addr_sext;
        @(posedge mclk) disable iff (!rst_b)
        wr_en && wr_sel >= SEL_W'(NUM_DATA) && wr_sel < SEL_W'(NUM_REGS) && wr_size == SZ_WORD
        |=> reg_q[$past(wr_sel)] == {{16{$past(wr_data[15])}}, $past(wr_data[15:0])};
    endproperty
    a_addr_sext: assert property (p_addr_sext) else $error("address word not extended");

    property p_lanes;
        @(posedge mclk) disable iff (!rst_b)
        wr_only |-> be_w[wr_sel] == size_lanes(wr_size);
    endproperty
    a_lanes: assert property (p_lanes) else $error("lane enables wrong");

    c_byte: cover property (@(posedge mclk) disable iff (!rst_b) wr_only && wr_size == SZ_BYTE);
    c_wrap: cover property (@(posedge mclk) disable iff (!rst_b)
        bf_op == BF_INS && bf_offset == 5'h1C && bf_width == 5'h08);
    c_quad: cover property (@(posedge mclk) disable iff (!rst_b) q_en && q_hi_sel < q_lo_sel);
endmodule // drof_file

// [hw/drof_reg.sv]
// Shared constants and one byte-lane-enabled 32-bit register
`timescale 1ns/1ps
package drof_pkg;
    localparam int          DATA_W    = 32;
    localparam int          NUM_DATA  = 8;
    localparam int          NUM_ADDR  = 7;
    localparam int          NUM_SP    = 3;
    localparam int          NUM_REGS  = NUM_DATA + NUM_ADDR + NUM_SP;
    localparam int          SEL_W     = 5;
    localparam int          LANES     = DATA_W / 8;
    localparam logic [1:0]  SZ_BYTE   = 2'h0;
    localparam logic [1:0]  SZ_WORD   = 2'h1;
    localparam logic [1:0]  SZ_LONG   = 2'h2;
    localparam logic [3:0]  BE_BYTE   = 4'h1;
    localparam logic [3:0]  BE_WORD   = 4'h3;
    localparam logic [3:0]  BE_LONG   = 4'hF;
    localparam logic [1:0]  BCD_NONE  = 2'h0;
    localparam logic [1:0]  BCD_PACK  = 2'h1;
    localparam logic [1:0]  BCD_UNPK  = 2'h2;
    localparam logic [1:0]  BF_NONE   = 2'h0;
    localparam logic [1:0]  BF_EXT    = 2'h1;
    localparam logic [1:0]  BF_INS    = 2'h2;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
endpackage

module drof_reg import drof_pkg::*; (
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              rst_b,
    // Lane write
    input  wire logic [LANES-1:0]  be,
    input  wire logic [DATA_W-1:0] wd,
    // Stored value
    output logic      [DATA_W-1:0] q
);
    logic [DATA_W-1:0] q_q;
    logic [DATA_W-1:0] q_d;

    always_comb begin
        q_d = q_q;
        for (int l = 0; l < LANES; l++) begin
            if (be[l]) begin
                q_d[l*8 +: 8] = wd[l*8 +: 8];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            q_q <= REG_RESET;
        end else begin
            q_q <= q_d;
        end
    end

    assign q = q_q;
endmodule // drof_reg

// [tb/drof_dec_model.sv]
// Decoder-side model issuing sized requests into the register file
`timescale 1ns/1ps
module drof_dec_model import drof_pkg::*; (
    // Clock
    input  wire logic          mclk,
    // Sized write
    output logic               wr_en = 1'h0,
    output logic [SEL_W-1:0]   wr_sel = 5'h00,
    output logic [1:0]         wr_size = 2'h0,
    output logic [DATA_W-1:0]  wr_data = 32'h0,
    // Sized read
    output logic               rd_en = 1'h0,
    output logic [SEL_W-1:0]   rd_sel = 5'h00,
    output logic [1:0]         rd_size = 2'h0,
    output logic [1:0]         rd_bcd = 2'h0,
    // Bit field
    output logic [1:0]         bf_op = 2'h0,
    output logic [2:0]         bf_reg = 3'h0,
    output logic [4:0]         bf_offset = 5'h00,
    output logic [4:0]         bf_width = 5'h00,
    output logic               bf_signed = 1'h0,
    output logic [DATA_W-1:0]  bf_ins_data = 32'h0,
    // Quad word
    output logic               q_en = 1'h0,
    output logic [2:0]         q_hi_sel = 3'h0,
    output logic [2:0]         q_lo_sel = 3'h0,
    output logic [63:0]        q_data = 64'h0
);
    // Each request held for exactly one taking edge
    task automatic wr(input logic [4:0] s, input logic [1:0] z, input logic [31:0] d);
        @(posedge mclk);
        wr_en   <= 1'h1;
        wr_sel  <= s;
        wr_size <= z;
        wr_data <= d;
        @(posedge mclk);
        wr_en   <= 1'h0;
    endtask
    task automatic rd(input logic [4:0] s, input logic [1:0] z, input logic [1:0] b);
        @(posedge mclk);
        rd_en   <= 1'h1;
        rd_sel  <= s;
        rd_size <= z;
        rd_bcd  <= b;
        @(posedge mclk);
        rd_en   <= 1'h0;
    endtask
    task automatic bf(input logic [1:0] o, input logic [2:0] r, input logic [4:0] f,
                      input logic [4:0] w, input logic g, input logic [31:0] i);
        @(posedge mclk);
        bf_op       <= o;
        bf_reg      <= r;
        bf_offset   <= f;
        bf_width    <= w;
        bf_signed   <= g;
        bf_ins_data <= i;
        @(posedge mclk);
        bf_op       <= BF_NONE;
    endtask
    task automatic quad(input logic [2:0] h, input logic [2:0] l, input logic [63:0] d);
        @(posedge mclk);
        q_en     <= 1'h1;
        q_hi_sel <= h;
        q_lo_sel <= l;
        q_data   <= d;
        @(posedge mclk);
        q_en     <= 1'h0;
    endtask
endmodule // drof_dec_model

// [tb/drof_file_bench.sv]
// Self-checking bench for the register file
`timescale 1ns/1ps
module drof_file_bench import drof_pkg::*; ;
    logic              mclk = 1'h0;
    logic              rst_b = 1'h0;
    logic              wr_en, rd_en, bf_signed, q_en;
    logic [SEL_W-1:0]  wr_sel, rd_sel;
    logic [1:0]        wr_size, rd_size, rd_bcd, bf_op;
    logic [2:0]        bf_reg, q_hi_sel, q_lo_sel;
    logic [4:0]        bf_offset, bf_width;
    logic [DATA_W-1:0] wr_data, rd_data, bf_ins_data, bf_data;
    logic [63:0]       q_data;
    int                bad_count = 0;
    int                cmp_count = 0;
    int                cyc = 0;

    always #2.5 mclk = ~mclk;

    drof_dec_model i_dec (.mclk, .wr_en, .wr_sel, .wr_size, .wr_data, .rd_en, .rd_sel,
        .rd_size, .rd_bcd, .bf_op, .bf_reg, .bf_offset, .bf_width, .bf_signed, .bf_ins_data,
        .q_en, .q_hi_sel, .q_lo_sel, .q_data);
    drof_file i_dut (.mclk, .rst_b, .wr_en, .wr_sel, .wr_size, .wr_data, .rd_en, .rd_sel,
        .rd_size, .rd_bcd, .rd_data, .bf_op, .bf_reg, .bf_offset, .bf_width, .bf_signed,
        .bf_ins_data, .bf_data, .q_en, .q_hi_sel, .q_lo_sel, .q_data);

    task automatic results;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Whole run needs about 110 cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            results();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [4:0] s, input logic [1:0] z, input logic [1:0] b,
                       input logic [31:0] e);
        i_dec.rd(s, z, b);
        #1;
        check(rd_data, e);
    endtask
    task automatic bfc(input logic [1:0] o, input logic [2:0] r, input logic [4:0] f,
                       input logic [4:0] w, input logic g, input logic [31:0] i,
                       input logic [31:0] e);
        i_dec.bf(o, r, f, w, g, i);
        #1;
        check(bf_data, e);
    endtask

    task automatic t_data;
        #1;
        check(bf_data, REG_RESET);
        rdc(5'h07, SZ_LONG, BCD_NONE, REG_RESET);
        for (int i = 0; i < 8; i++) begin
            i_dec.wr(5'(i), SZ_LONG, 32'h1357_9BDF ^ (32'h11 << i));
        end
        for (int i = 0; i < 8; i++) begin
            rdc(5'(i), SZ_LONG, BCD_NONE, 32'h1357_9BDF ^ (32'h11 << i));
        end
        $display("data registers done");
    endtask
    task automatic t_sized;
        i_dec.wr(5'h02, SZ_LONG, 32'h1122_3344);
        i_dec.wr(5'h02, SZ_BYTE, 32'hFFFF_FFAB);
        rdc(5'h02, SZ_LONG, BCD_NONE, 32'h1122_33AB);
        i_dec.wr(5'h02, SZ_WORD, 32'hFFFF_CDEF);
        rdc(5'h02, SZ_LONG, BCD_NONE, 32'h1122_CDEF);
        rdc(5'h02, SZ_BYTE, BCD_NONE, 32'h0000_00EF);
        rdc(5'h02, SZ_WORD, BCD_NONE, 32'h0000_CDEF);
        $display("sized access done");
    endtask
    task automatic t_field;
        i_dec.wr(5'h03, SZ_LONG, 32'h8000_0000);
        bfc(BF_EXT, 3'h3, 5'h1F, 5'h02, 1'h0, 32'h0, 32'h0000_0001);
        bfc(BF_EXT, 3'h3, 5'h00, 5'h01, 1'h0, 32'h0, 32'h0000_0001);
        i_dec.wr(5'h03, SZ_LONG, 32'hA000_0005);
        bfc(BF_EXT, 3'h3, 5'h00, 5'h00, 1'h0, 32'h0, 32'hA000_0005);
        bfc(BF_EXT, 3'h3, 5'h00, 5'h04, 1'h1, 32'h0, 32'hFFFF_FFFA);
        i_dec.wr(5'h04, SZ_LONG, 32'h0);
        #1;
        check(bf_data, 32'hFFFF_FFFA);
        bfc(BF_INS, 3'h4, 5'h1E, 5'h04, 1'h0, 32'h9, 32'h0);
        rdc(5'h04, SZ_LONG, BCD_NONE, 32'h4000_0002);
        $display("bit field done");
    endtask
    task automatic t_misc;
        i_dec.quad(3'h6, 3'h1, 64'hDEAD_BEEF_0123_4567);
        rdc(5'h06, SZ_LONG, BCD_NONE, 32'hDEAD_BEEF);
        rdc(5'h01, SZ_LONG, BCD_NONE, 32'h0123_4567);
        i_dec.quad(3'h0, 3'h7, 64'h0F1E_2D3C_4B5A_6978);
        rdc(5'h00, SZ_LONG, BCD_NONE, 32'h0F1E_2D3C);
        rdc(5'h07, SZ_LONG, BCD_NONE, 32'h4B5A_6978);
        i_dec.wr(5'h05, SZ_LONG, 32'hFFFF_F5F3);
        rdc(5'h05, SZ_WORD, BCD_PACK, 32'h0000_0053);
        i_dec.wr(5'h05, SZ_LONG, 32'h0000_0047);
        rdc(5'h05, SZ_BYTE, BCD_UNPK, 32'h0000_0407);
        i_dec.wr(5'h08, SZ_LONG, 32'h8765_4321);
        rdc(5'h08, SZ_LONG, BCD_NONE, 32'h8765_4321);
        i_dec.wr(5'h11, SZ_WORD, 32'h0000_8001);
        rdc(5'h11, SZ_LONG, BCD_NONE, 32'hFFFF_8001);
        rdc(5'h11, SZ_BYTE, BCD_NONE, 32'h0000_8001);
        i_dec.wr(5'h14, SZ_LONG, 32'h5A5A_5A5A);
        rdc(5'h14, SZ_LONG, BCD_NONE, 32'h0);
        $display("quad, decimal and address done");
    endtask

    initial begin
        repeat (10) @(posedge mclk);
        rst_b <= 1'h1;
        t_data();
        t_sized();
        t_field();
        t_misc();
        results();
    end
endmodule // drof_file_bench
